// file: common/iwc_pkg.sv
// Shared constants of the interrupt and watchdog controller
package iwc_pkg;
  // Clock and watchdog oscillator timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WDT_TICK_NS = 1000;
  localparam int unsigned WDT_TICK_CYCLES = (WDT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDT_PER0_US = 3500;
  localparam int unsigned WDT_PER1_US = 15000;
  localparam int unsigned WDT_PER2_US = 60000;
  localparam int unsigned WDT_PER3_US = 250000;
  localparam int unsigned WDT_PER0_TICKS = WDT_PER0_US * 1000 / WDT_TICK_NS;
  localparam int unsigned WDT_PER1_TICKS = WDT_PER1_US * 1000 / WDT_TICK_NS;
  localparam int unsigned WDT_PER2_TICKS = WDT_PER2_US * 1000 / WDT_TICK_NS;
  localparam int unsigned WDT_PER3_TICKS = WDT_PER3_US * 1000 / WDT_TICK_NS;
  localparam int unsigned WDT_CNT_W = 18;
  localparam int unsigned PRESC_W = 9;

  // Fetch vectors
  localparam int unsigned VEC_W = 11;
  localparam logic [VEC_W-1:0] SW_VECTOR = 11'h001;
  localparam logic [VEC_W-1:0] HW_VECTOR = 11'h008;

  // Register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] FLAG_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] ENABLE_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] POWER_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] PRESC_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] PORTCFG_OFF = 8'h14;

  // Flag and enable bit positions
  localparam int unsigned NUM_SRC = 7;
  localparam int unsigned FLAG_TIMER_A = 0;
  localparam int unsigned FLAG_PORT_CHG = 1;
  localparam int unsigned FLAG_EXT_PIN = 2;
  localparam int unsigned FLAG_TIMER_B = 3;
  localparam int unsigned FLAG_NV_DONE = 4;
  localparam int unsigned FLAG_LOW_VOLT = 5;
  localparam int unsigned FLAG_WATCHDOG = 6;

  // Other field positions
  localparam int unsigned POWER_RUN_BIT = 7;
  localparam int unsigned STATUS_GIE_BIT = 0;
  localparam int unsigned STATUS_TIMEOUT_BIT = 4;
  localparam int unsigned PRESC_SEL_LSB = 0;
  localparam int unsigned PRESC_ASSIGN_BIT = 3;
  localparam int unsigned PORT_PINS = 6;
  localparam int unsigned PORTCFG_EXT_SEL_BIT = 8;
  localparam int unsigned PORTCFG_EDGE_BIT = 9;

  // Reset values
  localparam logic RUN_ENABLE_RESET = 1'b1;
  localparam logic TIMEOUT_RESET = 1'b1;
  localparam logic GIE_RESET = 1'b0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/iwc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module iwc_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pins
  input wire logic [WIDTH-1:0] pinAsync,
  // Filtered level and one-cycle edges
  output logic [WIDTH-1:0] levelQ,
  output logic [WIDTH-1:0] riseQ,
  output logic [WIDTH-1:0] fallQ
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  wire [WIDTH-1:0] agree = ~(stage2_q ^ stage3_q);
  wire [WIDTH-1:0] level_d = (levelQ & ~agree) | (stage3_q & agree);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_q <= INIT;
      stage2_q <= INIT;
      stage3_q <= INIT;
      levelQ <= INIT;
      riseQ <= '0;
      fallQ <= '0;
    end else begin
      stage1_q <= pinAsync;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      levelQ <= level_d;
      riseQ <= level_d & ~levelQ;
      fallQ <= ~level_d & levelQ;
    end
  end
endmodule

// file: design/iwc_top.sv
// Interrupt controller with watchdog timer and AXI4-Lite register access
// Contract
// - Watchdog counts only while configuration enable and run-enable register bit are both set.
// - Configuration input chooses device reset or watchdog interrupt on expiry.
// - Every watchdog expiry clears the time-out status bit 4 to 0.
// - Base expiry period is 3.5, 15, 60 or 250 ms by two-bit select.
// - Prescaler-assign bit at 1 lengthens the period by the prescaler ratio.
// - Ratio is 1:1..1:128 in reset mode, 1:2..1:256 in interrupt mode.
// - Watchdog-clear instruction clears both counts and sets the time-out bit.
// - Interrupt-mode expiry sets flag bit 6; request needs enable 6 and global enable.
// - Software interrupt vectors to 0x001 regardless and clears global enable.
// - Return instruction sets global enable and resumes the interrupted code.
// - Seven hardware sources are supported.
// - Hardware interrupts need global enable; enable sets it, disable clears it.
// - Hardware sets flags; only a firmware write of 0 clears them.
// - A flag reads as 1 only when its enable bit is 1.
// - Enabled pending flag with global enable vectors to 0x008 and clears global enable.
// - Timer A wrap from 0x00 to 0xFF sets its flag.
// - Timer B underflow sets its flag.
// - Level change on selected input pins 0..5 sets the port-change flag.
// - External select bit removes pin 0 from level-change detection.
// - Selected edge on pin 0 sets the external flag when external select is 1.
// - Low-voltage falling edge and write completion set their flags.
`timescale 1ns/100ps
module iwc_top #(
  parameter int unsigned PERIOD0_TICKS = iwc_pkg::WDT_PER0_TICKS,
  parameter int unsigned PERIOD1_TICKS = iwc_pkg::WDT_PER1_TICKS,
  parameter int unsigned PERIOD2_TICKS = iwc_pkg::WDT_PER2_TICKS,
  parameter int unsigned PERIOD3_TICKS = iwc_pkg::WDT_PER3_TICKS,
  parameter int unsigned TICK_CYCLES = iwc_pkg::WDT_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [iwc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [iwc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration words
  input wire logic wdtConfigEnable,
  input wire logic wdtResetMode,
  input wire logic [1:0] wdtPeriodSelect,
  // Instruction strobes from the core sequencer
  input wire logic swIrqInstr,
  input wire logic enableIrqsInstr,
  input wire logic disableIrqsInstr,
  input wire logic returnFromIrqInstr,
  input wire logic watchdogClearInstr,
  // Event sources on this clock
  input wire logic timerAWrap,
  input wire logic timerBUnderflow,
  input wire logic nvWriteDone,
  input wire logic [iwc_pkg::PORT_PINS-1:0] portBIsInput,
  // Pins
  input wire logic [iwc_pkg::PORT_PINS-1:0] portBPins,
  input wire logic lowVoltageOut,
  // Core redirection and watchdog reset
  output logic fetchRedirect,
  output logic [iwc_pkg::VEC_W-1:0] fetchAddr,
  output logic globalIrqEnable,
  output logic watchdogResetReq
);
  localparam int unsigned CNT_W = iwc_pkg::WDT_CNT_W;
  localparam int unsigned PW = iwc_pkg::PRESC_W;
  localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int unsigned NS = iwc_pkg::NUM_SRC;

  if (TICK_CYCLES < 1 || PERIOD0_TICKS < 1 || PERIOD1_TICKS < 1 || PERIOD2_TICKS < 1 || PERIOD3_TICKS < 1 ||
      PERIOD0_TICKS >= 2**CNT_W || PERIOD1_TICKS >= 2**CNT_W || PERIOD2_TICKS >= 2**CNT_W ||
      PERIOD3_TICKS >= 2**CNT_W) begin : g_check
    $error("iwc_top: watchdog counts out of range");
  end

  // Bus capture registers
  logic awHeld_q;
  logic wHeld_q;
  logic [iwc_pkg::ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  // Control and state
  logic [NS-1:0] flags_q;
  logic [NS-1:0] enables_q;
  logic runEnable_q;
  logic timeout_q;
  logic gie_q;
  logic prescAssign_q;
  logic [2:0] prescSel_q;
  logic [iwc_pkg::PORT_PINS-1:0] wakeSel_q;
  logic extSel_q;
  logic edgeSel_q;
  logic [DIV_W-1:0] div_q;
  logic [CNT_W-1:0] wdtCount_q;
  logic [PW-1:0] prescCount_q;
  logic redirect_q;
  logic [iwc_pkg::VEC_W-1:0] fetchAddr_q;
  logic wdtReset_q;
  // Synchronised pins
  logic [iwc_pkg::PORT_PINS-1:0] pbLevel;
  logic [iwc_pkg::PORT_PINS-1:0] pbRise;
  logic [iwc_pkg::PORT_PINS-1:0] pbFall;
  logic lvdLevel;
  logic lvdRise;
  logic lvdFall;

  iwc_pin_sync #(.WIDTH(iwc_pkg::PORT_PINS), .INIT('0)) u_port_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinAsync(portBPins),
    .levelQ(pbLevel),
    .riseQ(pbRise),
    .fallQ(pbFall)
  );

  // Detector output idles high, so it starts high to avoid a false event
  iwc_pin_sync #(.WIDTH(1), .INIT(1'b1)) u_lvd_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinAsync(lowVoltageOut),
    .levelQ(lvdLevel),
    .riseQ(lvdRise),
    .fallQ(lvdFall)
  );

  // AXI handshakes
  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire doWrite = awHeld_q && wHeld_q && !bvalid_q;

  // Write decode
  wire wrFlag = doWrite && awAddr_q == iwc_pkg::FLAG_OFF;
  wire wrEnable = doWrite && awAddr_q == iwc_pkg::ENABLE_OFF;
  wire wrPower = doWrite && awAddr_q == iwc_pkg::POWER_OFF;
  wire wrPresc = doWrite && awAddr_q == iwc_pkg::PRESC_OFF;
  wire wrPortCfg = doWrite && awAddr_q == iwc_pkg::PORTCFG_OFF;
  wire wrStatus = doWrite && awAddr_q == iwc_pkg::STATUS_OFF;
  wire wrMapped = wrFlag || wrEnable || wrPower || wrPresc || wrPortCfg || wrStatus;
  wire [NS-1:0] flagClr = (wrFlag && wStrb_q[0]) ? ~wData_q[NS-1:0] : '0;

  // Watchdog base timebase from its own oscillator tick
  wire wdtRun = wdtConfigEnable && runEnable_q;
  wire wdtTick = div_q == DIV_W'(TICK_CYCLES - 1);
  wire [CNT_W-1:0] periodTicks = (wdtPeriodSelect == 2'h0) ? CNT_W'(PERIOD0_TICKS) :
                                 (wdtPeriodSelect == 2'h1) ? CNT_W'(PERIOD1_TICKS) :
                                 (wdtPeriodSelect == 2'h2) ? CNT_W'(PERIOD2_TICKS) :
                                 CNT_W'(PERIOD3_TICKS);
  wire baseExpire = wdtRun && wdtTick && wdtCount_q == periodTicks - CNT_W'(1);
  // Interrupt mode doubles every ratio of the shared prescaler
  wire [PW-1:0] prescRatio = wdtResetMode ? (PW'(1) << prescSel_q) : (PW'(2) << prescSel_q);
  wire prescWrap = prescCount_q == prescRatio - PW'(1);
  wire wdtExpire = baseExpire && !watchdogClearInstr && (!prescAssign_q || prescWrap);

  // Event detection
  logic [iwc_pkg::PORT_PINS-1:0] extMask;
  always_comb begin
    extMask = '0;
    extMask[0] = extSel_q;
  end
  wire [iwc_pkg::PORT_PINS-1:0] chgMask = portBIsInput & wakeSel_q & ~extMask;
  wire portChange = |((pbRise | pbFall) & chgMask);
  wire extEdge = extSel_q && (edgeSel_q ? pbRise[0] : pbFall[0]);

  logic [NS-1:0] flagSet;
  always_comb begin
    flagSet = '0;
    flagSet[iwc_pkg::FLAG_TIMER_A] = timerAWrap;
    flagSet[iwc_pkg::FLAG_TIMER_B] = timerBUnderflow;
    flagSet[iwc_pkg::FLAG_PORT_CHG] = portChange;
    flagSet[iwc_pkg::FLAG_EXT_PIN] = extEdge;
    flagSet[iwc_pkg::FLAG_LOW_VOLT] = lvdFall;
    flagSet[iwc_pkg::FLAG_NV_DONE] = nvWriteDone;
    flagSet[iwc_pkg::FLAG_WATCHDOG] = wdtExpire && !wdtResetMode;
  end
  // Set wins over clear so an event in the clearing cycle survives
  wire [NS-1:0] flags_d = (flags_q & ~flagClr) | flagSet;
  wire [NS-1:0] visible = flags_q & enables_q;

  // One shared vector, any enabled source, no ranking between them
  wire hwTake = gie_q && (|visible) && !swIrqInstr;
  logic gie_d;
  always_comb begin
    if (swIrqInstr || hwTake) begin
      gie_d = 1'b0;
    end else if (returnFromIrqInstr || enableIrqsInstr) begin
      gie_d = 1'b1;
    end else if (disableIrqsInstr) begin
      gie_d = 1'b0;
    end else begin
      gie_d = gie_q;
    end
  end

  // Read mux
  logic [31:0] rdMux;
  logic rdMapped;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      iwc_pkg::FLAG_OFF: rdMux[NS-1:0] = visible;
      iwc_pkg::ENABLE_OFF: rdMux[NS-1:0] = enables_q;
      iwc_pkg::POWER_OFF: rdMux[iwc_pkg::POWER_RUN_BIT] = runEnable_q;
      iwc_pkg::STATUS_OFF: begin
        rdMux[iwc_pkg::STATUS_TIMEOUT_BIT] = timeout_q;
        rdMux[iwc_pkg::STATUS_GIE_BIT] = gie_q;
      end
      iwc_pkg::PRESC_OFF: begin
        rdMux[iwc_pkg::PRESC_ASSIGN_BIT] = prescAssign_q;
        rdMux[iwc_pkg::PRESC_SEL_LSB +: 3] = prescSel_q;
      end
      iwc_pkg::PORTCFG_OFF: begin
        rdMux[iwc_pkg::PORT_PINS-1:0] = wakeSel_q;
        rdMux[iwc_pkg::PORTCFG_EXT_SEL_BIT] = extSel_q;
        rdMux[iwc_pkg::PORTCFG_EDGE_BIT] = edgeSel_q;
      end
      default: rdMapped = 1'b0;
    endcase
  end

  // Bus channel state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= iwc_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= iwc_pkg::RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q <= wrMapped ? iwc_pkg::RESP_OKAY : iwc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (arTake) begin
        rvalid_q <= 1'b1;
        rdata_q <= rdMux;
        rresp_q <= rdMapped ? iwc_pkg::RESP_OKAY : iwc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Software-written control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enables_q <= '0;
      runEnable_q <= iwc_pkg::RUN_ENABLE_RESET;
      prescAssign_q <= 1'b0;
      prescSel_q <= 3'h0;
      wakeSel_q <= '0;
      extSel_q <= 1'b0;
      edgeSel_q <= 1'b0;
    end else begin
      if (wrEnable && wStrb_q[0]) begin
        enables_q <= wData_q[NS-1:0];
      end
      if (wrPower && wStrb_q[0]) begin
        runEnable_q <= wData_q[iwc_pkg::POWER_RUN_BIT];
      end
      if (wrPresc && wStrb_q[0]) begin
        prescAssign_q <= wData_q[iwc_pkg::PRESC_ASSIGN_BIT];
        prescSel_q <= wData_q[iwc_pkg::PRESC_SEL_LSB +: 3];
      end
      if (wrPortCfg && wStrb_q[0]) begin
        wakeSel_q <= wData_q[iwc_pkg::PORT_PINS-1:0];
      end
      if (wrPortCfg && wStrb_q[1]) begin
        extSel_q <= wData_q[iwc_pkg::PORTCFG_EXT_SEL_BIT];
        edgeSel_q <= wData_q[iwc_pkg::PORTCFG_EDGE_BIT];
      end
    end
  end

  // Flags, global enable and fetch redirection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= '0;
      gie_q <= iwc_pkg::GIE_RESET;
      redirect_q <= 1'b0;
      fetchAddr_q <= '0;
    end else begin
      flags_q <= flags_d;
      gie_q <= gie_d;
      redirect_q <= swIrqInstr || hwTake;
      if (swIrqInstr) begin
        fetchAddr_q <= iwc_pkg::SW_VECTOR;
      end else if (hwTake) begin
        fetchAddr_q <= iwc_pkg::HW_VECTOR;
      end
    end
  end

  // Watchdog counters and time-out status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= '0;
      wdtCount_q <= '0;
      prescCount_q <= '0;
      timeout_q <= iwc_pkg::TIMEOUT_RESET;
      wdtReset_q <= 1'b0;
    end else begin
      div_q <= wdtTick ? '0 : div_q + DIV_W'(1);
      wdtReset_q <= wdtExpire && wdtResetMode;
      if (watchdogClearInstr) begin
        wdtCount_q <= '0;
        prescCount_q <= '0;
        timeout_q <= 1'b1;
      end else begin
        if (wdtRun && wdtTick) begin
          wdtCount_q <= baseExpire ? '0 : wdtCount_q + CNT_W'(1);
        end
        // Prescaler count only moves while it belongs to the watchdog
        if (baseExpire && prescAssign_q) begin
          prescCount_q <= prescWrap ? '0 : prescCount_q + PW'(1);
        end
        if (wdtExpire) begin
          timeout_q <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign fetchRedirect = redirect_q;
  assign fetchAddr = fetchAddr_q;
  assign globalIrqEnable = gie_q;
  assign watchdogResetReq = wdtReset_q;

  // Helper terms for the checks below
  wire [NS-1:0] keepMask = flags_q & ~flagClr;

  AST_HW_VECTOR: assert property (@(posedge clk) disable iff (!rst_n)
    hwTake |=> redirect_q && fetchAddr_q == iwc_pkg::HW_VECTOR && !gie_q ##1 !redirect_q)
    else $error("hardware take did not vector to 0x008");
  AST_SW_VECTOR: assert property (@(posedge clk) disable iff (!rst_n)
    swIrqInstr |=> redirect_q && fetchAddr_q == iwc_pkg::SW_VECTOR && !gie_q)
    else $error("software interrupt did not vector to 0x001");
  AST_RETURN_GIE: assert property (@(posedge clk) disable iff (!rst_n)
    returnFromIrqInstr && !swIrqInstr && !hwTake |=> gie_q)
    else $error("return did not set global enable");
  AST_DISABLE_GIE: assert property (@(posedge clk) disable iff (!rst_n)
    disableIrqsInstr && !enableIrqsInstr && !returnFromIrqInstr && !hwTake |=> !gie_q && !redirect_q ##1 !redirect_q)
    else $error("disable did not clear global enable");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (flags_q & $past(keepMask)) == $past(keepMask))
    else $error("flag cleared without firmware write");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> (flags_q & $past(flagSet)) == $past(flagSet))
    else $error("event lost against clear");
  AST_READ_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    arTake && s_axi_araddr == iwc_pkg::FLAG_OFF |=> rdata_q[NS-1:0] == $past(visible) && rvalid_q)
    else $error("flag read not masked by enables");
  AST_TIMEOUT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    wdtExpire |=> !timeout_q)
    else $error("expiry did not clear time-out bit");
  AST_CLEAR_INSTR: assert property (@(posedge clk) disable iff (!rst_n)
    watchdogClearInstr |=> timeout_q && wdtCount_q == '0 && prescCount_q == '0)
    else $error("watchdog clear incomplete");
  AST_WDT_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
    wdtExpire && !wdtResetMode |=> flags_q[iwc_pkg::FLAG_WATCHDOG] && !watchdogResetReq)
    else $error("interrupt-mode expiry did not set flag");
  AST_WDT_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    wdtExpire && wdtResetMode |=> watchdogResetReq ##1 !watchdogResetReq)
    else $error("reset-mode expiry did not pulse reset");
  AST_WDT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !wdtRun && !watchdogClearInstr |=> $stable(wdtCount_q))
    else $error("watchdog counted while stopped");
endmodule

// file: dv/iwc_core_model.sv
// Core sequencer model: closes each interrupt granted while retEnable is high with a return strobe
`timescale 1ns/100ps
module iwc_core_model (
  // Clock
  input wire logic clk,
  // Redirect from the controller and bench permission to return
  input wire logic fetchRedirect,
  input wire logic retEnable,
  input wire logic enableIrqsInstr,
  // Return strobe to the controller
  output logic returnFromIrqInstr
);
  logic [2:0] delayQ;
  logic pendQ;
  initial delayQ = 3'h0;
  initial pendQ = 1'b0;
  initial returnFromIrqInstr = 1'b0;
  // Returns four cycles after the redirect cycle and never right after an enable strobe
  always @(posedge clk) begin
    delayQ <= {delayQ[1:0], fetchRedirect & retEnable};
    // An enable just before the return could lose a flag, so the return waits a cycle
    if ((pendQ || delayQ[2]) && !enableIrqsInstr) begin
      returnFromIrqInstr <= 1'b1;
      pendQ <= 1'b0;
    end else begin
      returnFromIrqInstr <= 1'b0;
      pendQ <= pendQ || delayQ[2];
    end
  end
endmodule

// file: dv/iwc_top_tb.sv
// Self-checking bench of the interrupt and watchdog controller
`timescale 1ns/100ps
module iwc_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, retEnable = 1'b0, cfgEn = 1'b0, resetMode = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, fetchRedirect, global_irq_enable, wdtReset, retInstr;
  logic [1:0] bresp, rresp, period = 2'h0;
  logic [10:0] fetchAddr;
  logic [3:0] ins = 4'h0;
  logic [5:0] ev = 6'h00;
  logic [6:0] en, fl;
  logic [3:0] wstrb = 4'hF, pbHi = 4'h0;
  logic [5:0] pbIn = 6'h3F;
  logic [1:0] respQ[$];
  int rstBase = 0;
  logic [33:0] readQ[$];
  logic [10:0] fetchQ[$];
  int miscompares = 0, comparisons = 0, rstCount = 0, seed = 32'hFD3B;

  iwc_top #(.PERIOD0_TICKS(4), .PERIOD1_TICKS(6), .PERIOD2_TICKS(8), .PERIOD3_TICKS(10), .TICK_CYCLES(1)) dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wdtConfigEnable(cfgEn), .wdtResetMode(resetMode),
    .wdtPeriodSelect(period), .swIrqInstr(ins[0]), .enableIrqsInstr(ins[1]), .disableIrqsInstr(ins[2]),
    .returnFromIrqInstr(retInstr), .watchdogClearInstr(ins[3]), .timerAWrap(ev[0]),
    .timerBUnderflow(ev[3]), .nvWriteDone(ev[4]), .portBIsInput(pbIn), .portBPins({pbHi, ev[1], ev[2]}),
    .lowVoltageOut(~ev[5]), .fetchRedirect(fetchRedirect), .fetchAddr(fetchAddr),
    .globalIrqEnable(global_irq_enable), .watchdogResetReq(wdtReset));
  iwc_core_model core (.clk(clk), .fetchRedirect(fetchRedirect), .retEnable(retEnable),
    .enableIrqsInstr(ins[1]), .returnFromIrqInstr(retInstr));

  initial forever #50 clk = ~clk;

  task automatic give_verdict;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_bus(input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_pin(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Ready is sampled mid-cycle; nothing moves between then and the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    respQ.push_back((a <= 8'h14 && a[1:0] == 2'h0) ? 2'h0 : 2'h2);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ta, tr;
    readQ.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arready;
      tr = rvalid;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ins[i] <= 1'b1;
    @(posedge clk);
    ins <= 4'h0;
  endtask

  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk_bus(readQ.pop_front(), {rresp, rdata});
    if (fetchRedirect === 1'b1) chk_pin(fetchQ.pop_front(), 32'(fetchAddr));
    if (bvalid === 1'b1 && bready === 1'b1) chk_pin(32'(respQ.pop_front()), 32'(bresp));
    if (wdtReset === 1'b1) rstCount <= rstCount + 1;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h0C, 34'h10);
    rd(8'h08, 34'h80);
    rd(8'h40, {2'h2, 32'h0});
    wr(8'h44, 32'h0);
    en = 7'($random(seed));
    wr(8'h04, {25'h0, en});
    wr(8'h14, 32'h303);
    // Pin 1 not an input and pins 2..5 not wake-selected: no port-change flag may follow
    pbIn <= 6'h3D;
    pbHi <= 4'($random(seed));
    ev[1] <= 1'b1;
    repeat (6) @(posedge clk);
    ev[1] <= 1'b0;
    pbHi <= 4'h0;
    repeat (8) @(posedge clk);
    pbIn <= 6'h3F;
    fl = 7'h00;
    // Pin 0 is wake-selected too, yet only its external flag may rise
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      ev[i] <= 1'b1;
      repeat (3) @(posedge clk);
      ev <= 6'h00;
      repeat (8) @(posedge clk);
      fl[i] = 1'b1;
      rd(8'h00, {27'h0, fl & en});
    end
    wr(8'h04, 32'h7F);
    // No byte lane enabled: the enables must stay as they are
    wstrb <= 4'h0;
    wr(8'h04, 32'h0);
    wstrb <= 4'hF;
    rd(8'h04, 34'h7F);
    wr(8'h00, 32'h7E);
    rd(8'h00, 34'h3E);
    fetchQ.push_back(11'h008);
    pulse(1);
    repeat (4) @(posedge clk);
    rd(8'h0C, 34'h10);
    wr(8'h00, 32'h0);
    retEnable <= 1'b1;
    fetchQ.push_back(11'h001);
    pulse(0);
    repeat (6) @(posedge clk);
    rd(8'h0C, 34'h11);
    chk_pin(32'h1, 32'(global_irq_enable));
    pulse(2);
    rd(8'h0C, 34'h10);
    wr(8'h10, 32'hF);
    cfgEn <= 1'b1;
    // Ratio 256 on a 4-tick base gives one expiry near cycle 1024
    repeat (1100) @(posedge clk);
    rd(8'h0C, 34'h0);
    rd(8'h00, 34'h40);
    pulse(3);
    rd(8'h0C, 34'h10);
    wr(8'h10, 32'h0);
    resetMode <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      period <= s[1:0];
      repeat (4) @(posedge clk);
      rstBase = rstCount;
      repeat (40 + 20 * s) @(posedge clk);
      chk_pin(32'h1, 32'(rstCount - rstBase >= 9 && rstCount - rstBase <= 11));
    end
    // Reset mode, ratio 2 on the 10-tick base: one reset every 20 cycles
    wr(8'h10, 32'h9);
    pulse(3);
    rstBase = rstCount;
    repeat (200) @(posedge clk);
    chk_pin(32'h1, 32'(rstCount - rstBase >= 9 && rstCount - rstBase <= 11));
    wr(8'h08, 32'h0);
    repeat (5) @(posedge clk);
    rstBase = rstCount;
    repeat (100) @(posedge clk);
    chk_pin(32'h0, 32'(rstCount - rstBase));
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
